// ==== design/flash_ctl_pkg.sv ====
// Package with register map, field positions and timing for flash control.
package flash_ctl_pkg;
  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [7:0]  OFF_CONTROL   = 8'h00;
  localparam logic [7:0]  OFF_KEY       = 8'h04;
  localparam logic [7:0]  OFF_TABLE_PAGE = 8'h08;
  localparam logic [7:0]  OFF_BUF_LOW   = 8'h0c;
  localparam logic [7:0]  OFF_BUF_HIGH  = 8'h10;
  localparam logic [7:0]  OFF_STATUS    = 8'h14;
  // Control register field positions.
  localparam int          BIT_START     = 15;
  localparam int          BIT_WRITE_ENABLE = 14;
  localparam int          BIT_SEQERR    = 13;
  localparam int          BIT_ERASE     = 6;
  // Reset value of the control register.
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  // Unlock key values.
  localparam logic [7:0]  KEY_FIRST     = 8'h55;
  localparam logic [7:0]  KEY_SECOND    = 8'haa;
  // Operation codes.
  localparam logic [3:0]  OP_BULK       = 4'hf;
  localparam logic [3:0]  OP_GENERAL    = 4'hd;
  localparam logic [3:0]  OP_SECURE     = 4'hc;
  localparam logic [3:0]  OP_WORD       = 4'h3;
  localparam logic [3:0]  OP_PAGE       = 4'h2;
  localparam logic [3:0]  OP_ROW        = 4'h1;
  localparam logic [3:0]  OP_CONFIG     = 4'h0;
  // Geometry: instructions per row, rows per page, bytes per row and per page.
  localparam int          ROW_WORDS     = 64;
  localparam int          PAGE_ROWS     = 8;
  localparam int          ROW_BYTES     = 192;
  localparam int          PAGE_BYTES    = 1536;
  // Self-timed operation: RC cycles and RC rate in kHz.
  localparam int          RC_CYCLES     = 11064;
  localparam int          RC_KHZ        = 7370;
  localparam int          CLK_KHZ       = 125000;
  localparam int          OP_CLKS       = (RC_CYCLES * (CLK_KHZ / 10)) /
                                          (RC_KHZ / 10);
  // AXI response codes.
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage : flash_ctl_pkg

// ==== design/flash_self_program_control.sv ====
// Run-time self-programming controller with AXI4-Lite register access.
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
module flash_self_program_control
  import flash_ctl_pkg::*;
#(
  parameter int OP_CYCLES = OP_CLKS  // Operation length in clocks.
) (
  // Clock and resets.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        por_n,
  // AXI4-Lite write address.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  // AXI4-Lite write data.
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  // AXI4-Lite write response.
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address.
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  // AXI4-Lite read data.
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Flash array command side.
  output var  logic        cpu_stall,
  output var  logic        flash_busy,
  output var  logic [3:0]  flash_op,
  output var  logic        flash_erase,
  output var  logic [23:0] flash_addr,
  output var  logic        buf_rd_en,
  output var  logic [23:0] buf_rd_data
);
  localparam int IW = $clog2(ROW_WORDS);

  // Bus capture state.
  logic        aw_held;                // Write address latched.
  logic        w_held;                 // Write data latched.
  logic [7:0]  aw_addr;                // Latched write address.
  logic [31:0] w_data;                 // Latched write data.
  logic [3:0]  w_strb;                 // Latched strobes.
  // Control register fields.
  logic        start_bit;              // Operation in flight.
  logic        write_enable;           // Permits operations.
  logic        sequence_error;         // Improper attempt flag.
  logic        erase_sel;              // Erase versus program.
  logic [3:0]  operation_code;         // Selected operation.
  // Unlock tracking.
  logic        key_half;               // First key seen last write.
  logic        unlocked;               // Key sequence complete.
  // Table pointer and holding buffer.
  logic [7:0]  table_page;             // Upper address byte.
  logic [15:0] table_offset;           // Last table write offset.
  logic [IW-1:0] buf_idx;              // Buffer index to read out.
  logic [15:0] buf_low  [ROW_WORDS];   // Low words of instructions.
  logic [7:0]  buf_high [ROW_WORDS];   // High bytes of instructions.
  // Operation timer.
  logic [$clog2(OP_CYCLES+1)-1:0] timer;
  logic        streaming;              // Row words left to stream.

  // Decode of a write that has both halves.
  wire         wr_fire   = aw_held & w_held & ~s_axi_bvalid;
  wire         wr_ctl    = wr_fire & (aw_addr == OFF_CONTROL);
  wire         wr_key    = wr_fire & (aw_addr == OFF_KEY) & w_strb[0];
  wire         wr_page   = wr_fire & (aw_addr == OFF_TABLE_PAGE);
  wire         wr_low    = wr_fire & (aw_addr == OFF_BUF_LOW);
  wire         wr_high   = wr_fire & (aw_addr == OFF_BUF_HIGH);
  wire         wr_known  = wr_ctl | (aw_addr == OFF_KEY) | wr_page |
                           wr_low | wr_high;
  wire [15:0]  wr_ofs    = w_data[31:16];
  // Buffer slot from the table offset: two address units per word.
  wire [IW-1:0] wr_slot  = wr_ofs[IW:1];
  wire         try_start = wr_ctl & w_strb[1] & w_data[BIT_START] &
                           ~start_bit;
  // Legal code for the selected kind.
  wire         erase_ok  = (w_data[3:0] == OP_BULK) |
                           (w_data[3:0] == OP_GENERAL) |
                           (w_data[3:0] == OP_SECURE) |
                           (w_data[3:0] == OP_PAGE) |
                           (w_data[3:0] == OP_CONFIG);
  wire         prog_ok   = (w_data[3:0] == OP_WORD) |
                           (w_data[3:0] == OP_ROW) |
                           (w_data[3:0] == OP_CONFIG);
  wire         code_ok   = w_data[BIT_ERASE] ? erase_ok : prog_ok;
  // A launch needs the unlock, write enable and a real code.
  wire         is_row    = ~w_data[BIT_ERASE] & (w_data[3:0] == OP_ROW);
  wire         launch    = try_start & unlocked &
                           w_data[BIT_WRITE_ENABLE] &
                           code_ok;
  wire         bad_try   = try_start & ~launch;
  wire         done      = start_bit & (timer == '0);
  // Row and page alignment of the target.
  wire [23:0]  raw_addr  = {table_page, table_offset};
  wire [23:0]  row_base  = raw_addr - (raw_addr % 24'(ROW_WORDS * 2));
  wire [23:0]  page_base = raw_addr -
                           (raw_addr % 24'(ROW_WORDS * 2 * PAGE_ROWS));
  wire [23:0]  tgt_addr  = (w_data[3:0] == OP_PAGE & w_data[BIT_ERASE]) ?
                           page_base :
                           ((w_data[3:0] == OP_ROW & ~w_data[BIT_ERASE]) ?
                           row_base : raw_addr);
  // Read mux.
  wire [15:0]  ctl_view  = {start_bit, write_enable, sequence_error,
                            6'h00, erase_sel, 2'h0, operation_code};
  wire [31:0]  rd_word   = (s_axi_araddr == OFF_CONTROL) ?
                           {16'h0000, ctl_view} :
                           (s_axi_araddr == OFF_TABLE_PAGE) ?
                           {24'h000000, table_page} :
                           (s_axi_araddr == OFF_STATUS) ?
                           {30'h0, unlocked, start_bit} : 32'h0;
  wire         rd_known  = (s_axi_araddr == OFF_CONTROL) |
                           (s_axi_araddr == OFF_KEY) |
                           (s_axi_araddr == OFF_TABLE_PAGE) |
                           (s_axi_araddr == OFF_BUF_LOW) |
                           (s_axi_araddr == OFF_BUF_HIGH) |
                           (s_axi_araddr == OFF_STATUS);

  // Write channel capture; address and data may come in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_held & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready  <= ~w_held & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        // Answer once both halves are in.
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one cycle from address to data.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        // Key register is write-only, so it reads zero.
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Control fields except a running start bit keep their values over a bus reset; only power-on clears them.
  always_ff @(posedge aclk) begin
    if (!por_n) begin
      {start_bit, write_enable, sequence_error} <= CONTROL_RESET[15:13];
      erase_sel      <= CONTROL_RESET[BIT_ERASE];
      operation_code <= CONTROL_RESET[3:0];
    end else begin
      if (wr_ctl && !start_bit) begin
        // Fields are frozen while an operation runs.
        if (w_strb[1]) begin
          write_enable <= w_data[BIT_WRITE_ENABLE];
        end
        if (w_strb[0]) begin
          erase_sel      <= w_data[BIT_ERASE];
          operation_code <= w_data[3:0];
        end
      end
      // Only hardware clears the start bit; set has no path while busy.
      if (launch) begin
        start_bit <= 1'b1;
      end else if (done) begin
        start_bit <= 1'b0;
      end
      // Error follows each start attempt, set winning.
      if (bad_try) begin
        sequence_error <= 1'b1;
      end else if (launch) begin
        sequence_error <= 1'b0;
      end
    end
  end

  // Unlock: 0x55 then 0xAA with no other write in between; consumed by
  // any start attempt.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_half <= 1'b0;
      unlocked <= 1'b0;
    end else if (wr_fire) begin
      key_half <= wr_key & (w_data[7:0] == KEY_FIRST);
      if (try_start) begin
        unlocked <= 1'b0;
      end else if (wr_key) begin
        unlocked <= key_half & (w_data[7:0] == KEY_SECOND);
      end else begin
        unlocked <= 1'b0;
      end
    end
  end

  // Table pointer and holding buffer; writes never reach the array.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      table_page   <= 8'h00;
      table_offset <= 16'h0000;
    end else begin
      if (wr_page) begin
        table_page <= w_data[7:0];
      end
      if (wr_low | wr_high) begin
        table_offset <= wr_ofs;
      end
    end
  end

  for (genvar i = 0; i < ROW_WORDS; i++) begin : g_buf
    always_ff @(posedge aclk) begin
      if (wr_low && wr_slot == IW'(i)) begin
        buf_low[i] <= w_data[15:0];
      end
      if (wr_high && wr_slot == IW'(i)) begin
        buf_high[i] <= w_data[7:0];
      end
    end
  end

  // Self-timed operation and the flash command outputs.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer       <= '0;
      cpu_stall   <= 1'b0;
      flash_busy  <= 1'b0;
      flash_op    <= 4'h0;
      flash_erase <= 1'b0;
      flash_addr  <= 24'h0;
      buf_rd_en   <= 1'b0;
      buf_idx     <= '0;
      buf_rd_data <= 24'h0;
      streaming   <= 1'b0;
    end else begin
      buf_rd_en <= 1'b0;
      if (launch) begin
        timer       <= $bits(timer)'(OP_CYCLES - 1);
        cpu_stall   <= 1'b1;
        flash_busy  <= 1'b1;
        flash_op    <= w_data[3:0];
        flash_erase <= w_data[BIT_ERASE];
        flash_addr  <= tgt_addr;
        buf_idx     <= '0;
        streaming   <= is_row;
      end else if (done) begin
        cpu_stall  <= 1'b0;
        flash_busy <= 1'b0;
        streaming  <= 1'b0;
      end else if (start_bit) begin
        timer <= timer - 1'b1;
        // A row program streams each buffered word exactly once; the
        // operation must outlast one row or the tail is never sent.
        if (streaming) begin
          buf_rd_en   <= 1'b1;
          buf_rd_data <= {buf_high[buf_idx], buf_low[buf_idx]};
          buf_idx     <= buf_idx + 1'b1;
          streaming   <= (buf_idx != '1);
        end
      end
    end
  end

  // Checks on the sequencer.
  property p_stall_with_start;
    @(posedge aclk) disable iff (!aresetn)
      start_bit |=> ##0 (cpu_stall | $fell(start_bit));
  endproperty
  a_stall_with_start: assert property (p_stall_with_start)
    else $error("stall missing during operation");

  property p_no_start_locked;
    @(posedge aclk) disable iff (!aresetn)
      (try_start & ~unlocked) |=> sequence_error & ~flash_busy;
  endproperty
  a_no_start_locked: assert property (p_no_start_locked)
    else $error("start accepted without unlock");

  property p_write_enable_gate;
    @(posedge aclk) disable iff (!aresetn)
      (try_start & ~w_data[BIT_WRITE_ENABLE]) |=> ~flash_busy;
  endproperty
  a_write_enable_gate: assert property (p_write_enable_gate)
    else $error("operation started with writes inhibited");

  property p_consume;
    @(posedge aclk) disable iff (!aresetn)
      try_start |=> ~unlocked;
  endproperty
  a_consume: assert property (p_consume)
    else $error("unlock survived a start attempt");

  property p_bad_code;
    @(posedge aclk) disable iff (!aresetn)
      (try_start & ~code_ok) |=> ~flash_busy & sequence_error;
  endproperty
  a_bad_code: assert property (p_bad_code)
    else $error("unlisted code started activity");

  property p_launch_busy;
    @(posedge aclk) disable iff (!aresetn || !por_n)
      launch |=> start_bit & flash_busy & ~sequence_error;
  endproperty
  a_launch_busy: assert property (p_launch_busy)
    else $error("launch did not start operation");

  property p_row_align;
    @(posedge aclk) disable iff (!aresetn)
      $rose(flash_busy) & (flash_op == OP_ROW) & ~flash_erase |->
        (flash_addr % 24'(ROW_WORDS * 2)) == 24'h0;
  endproperty
  a_row_align: assert property (p_row_align)
    else $error("row target not aligned");

  property p_key_zero;
    @(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid & s_axi_arready & (s_axi_araddr == OFF_KEY)) |=>
        s_axi_rdata == 32'h0;
  endproperty
  a_key_zero: assert property (p_key_zero)
    else $error("key register read nonzero");

  c_launch: cover property (@(posedge aclk) disable iff (!aresetn) launch);
  c_done: cover property (@(posedge aclk) disable iff (!aresetn) done);
  c_bad: cover property (@(posedge aclk) disable iff (!aresetn) bad_try);
endmodule : flash_self_program_control
`default_nettype wire

// ==== tb/flash_self_program_control_bench.sv ====
// Self-checking bench for the flash self-programming controller.
`timescale 1ns/10ps
`default_nettype none
module flash_self_program_control_bench;
  import flash_ctl_pkg::*;
  // Short operation that still outlasts the stream of one row.
  localparam int OPC = 80;
  // Clock, resets and bus requests driven by the bench.
  logic        aclk, aresetn, por_n;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  // Outputs of the design.
  logic        awready, wready, bvalid, arready, rvalid;
  logic        cpu_stall, flash_busy, flash_erase, buf_rd_en;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [3:0]  flash_op;
  logic [23:0] flash_addr, buf_rd_data;
  // Expected results waiting for the monitor, oldest first.
  logic [1:0]  exp_b[$];
  logic [33:0] exp_r[$];
  logic [23:0] exp_w[$];
  logic [33:0] e;
  int          err_count, check_count, stall_cycles, pulses, seed;

  flash_self_program_control #(.OP_CYCLES(OPC)) DUT (
    .aclk(aclk), .aresetn(aresetn), .por_n(por_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cpu_stall(cpu_stall),
    .flash_busy(flash_busy), .flash_op(flash_op), .flash_erase(flash_erase),
    .flash_addr(flash_addr), .buf_rd_en(buf_rd_en),
    .buf_rd_data(buf_rd_data));

  // Free-running 125 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // Compares a value and counts the outcome.
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp_val

  // Compares a bus response code and counts the outcome.
  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp,
                          input string what);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp_resp

  // Monitor takes the oldest note whenever a result appears.
  always @(posedge aclk) begin
    if (bvalid && bready) cmp_resp(bresp, exp_b.pop_front(), "bresp");
    if (rvalid && rready) begin
      e = exp_r.pop_front();
      cmp_resp(rresp, e[33:32], "rresp");
      cmp_val(rdata, e[31:0], "rdata");
    end
    if (buf_rd_en === 1'b1) begin
      pulses++;
      e = {10'h0, exp_w.pop_front()};
      cmp_val({8'h00, buf_rd_data}, e[31:0], "word");
    end
    if (cpu_stall === 1'b1) stall_cycles++;
    if (cpu_stall || flash_busy)
      cmp_val({31'h0, cpu_stall}, {31'h0, flash_busy}, "stall");
  end

  // One write; the trailing edge keeps two writes from colliding.
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [1:0] r);
    int n;
    n = 0;
    exp_b.push_back(r);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid || n > 60) break;
    end
    bready <= 1'b0;
    if (!bvalid) cmp_val(32'h0, 32'h1, "write answer");
    @(posedge aclk);
  endtask : axi_write

  // One read with its expected data and response.
  task automatic axi_read(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] r);
    int n;
    n = 0;
    exp_r.push_back({r, d});
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid || n > 60) break;
    end
    rready <= 1'b0;
    if (!rvalid) cmp_val(32'h0, 32'h1, "read answer");
    @(posedge aclk);
  endtask : axi_read

  // Back-to-back key writes that arm one operation.
  // No other write may slip between the keys, as if interrupts were held.
  task automatic unlock;
    axi_write(OFF_KEY, {24'h0, KEY_FIRST}, RESP_OKAY);
    axi_write(OFF_KEY, {24'h0, KEY_SECOND}, RESP_OKAY);
    axi_read(OFF_STATUS, 32'h2, RESP_OKAY);
  endtask : unlock

  // Sets the start bit and checks launch, duration and final state.
  task automatic start_op(input logic we, input logic er,
                          input logic [3:0] code, input logic legal);
    logic [31:0] v;
    int          n;
    v = {16'h0, 1'b1, we, 7'h0, er, 2'h0, code};
    stall_cycles = 0;
    n = 0;
    axi_write(OFF_CONTROL, v, RESP_OKAY);
    if (legal) begin
      // Software may not clear the start bit while the operation runs.
      axi_write(OFF_CONTROL, 32'h0, RESP_OKAY);
      axi_read(OFF_CONTROL, v, RESP_OKAY);
      axi_read(OFF_STATUS, 32'h1, RESP_OKAY);
    end
    // Sampled mid-cycle so the monitor's count for this edge has landed.
    while ((stall_cycles == 0 || cpu_stall) && n < OPC + 10) begin
      @(negedge aclk);
      n++;
    end
    @(posedge aclk);
    if (legal) begin
      cmp_val(32'(stall_cycles >= OPC && stall_cycles <= OPC + 3), 32'h1,
              "duration");
      cmp_val({28'h0, flash_op}, {28'h0, code}, "op code");
      cmp_val({31'h0, flash_erase}, {31'h0, er}, "erase");
    end else begin
      cmp_val(32'(stall_cycles), 32'h0, "no launch");
    end
    // Start clears on its own; the error flag reports a refused attempt.
    axi_read(OFF_CONTROL, {16'h0, 1'b0, we, !legal, v[12:0]},
             RESP_OKAY);
  endtask : start_op

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (30000) @(posedge aclk);
    err_count++;
    $display("FAIL %0t watchdog expired", $time);
    stop_test();
  end

  // Main sequence.
  initial begin
    logic [31:0] lo, hi;
    logic [15:0] off;
    logic        lg;
    seed = 32;
    err_count = 0;
    check_count = 0;
    pulses = 0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    aresetn = 1'b0;
    por_n = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    por_n <= 1'b1;
    @(posedge aclk);
    axi_read(OFF_CONTROL, 32'h0, RESP_OKAY);
    axi_read(OFF_KEY, 32'h0, RESP_OKAY);
    axi_write(8'h18, 32'h1, RESP_SLVERR);
    axi_read(8'h18, 32'h0, RESP_SLVERR);
    axi_write(OFF_CONTROL, 32'h0000_5fff, RESP_OKAY);
    axi_read(OFF_CONTROL, 32'h0000_404f, RESP_OKAY);
    start_op(1'b1, 1'b1, OP_PAGE, 1'b0);
    // A write between the two keys breaks the sequence.
    axi_write(OFF_KEY, {24'h0, KEY_FIRST}, RESP_OKAY);
    axi_write(OFF_TABLE_PAGE, 32'h0, RESP_OKAY);
    axi_write(OFF_KEY, {24'h0, KEY_SECOND}, RESP_OKAY);
    start_op(1'b1, 1'b1, OP_PAGE, 1'b0);
    unlock();
    start_op(1'b0, 1'b1, OP_PAGE, 1'b0);
    // Fill the whole row buffer with random words, then program it.
    axi_write(OFF_TABLE_PAGE, 32'h01, RESP_OKAY);
    for (int i = 0; i < 64; i++) begin
      lo = $random(seed);
      hi = $random(seed);
      off = 16'h0080 + 16'(2 * i);
      axi_write(OFF_BUF_LOW, {off, lo[15:0]}, RESP_OKAY);
      axi_write(OFF_BUF_HIGH, {off, 8'h0, hi[7:0]}, RESP_OKAY);
      exp_w.push_back({hi[7:0], lo[15:0]});
    end
    unlock();
    start_op(1'b1, 1'b0, OP_ROW, 1'b1);
    cmp_val(32'(pulses), 32'h40, "row words");
    cmp_val({8'h0, flash_addr}, 32'h0001_0080, "target");
    // Every code under both selections except row program, which would replay data.
    for (int er = 0; er < 2; er++) begin
      for (int c = 0; c < 16; c++) begin
        if (er == 0 && c == 1) continue;
        lg = (er == 1) ? (c inside {15, 13, 12, 2, 0}) : (c inside {3, 0});
        unlock();
        start_op(1'b1, er[0], c[3:0], lg);
      end
    end
    start_op(1'b1, 1'b1, OP_PAGE, 1'b0);
    // Bus reset alone keeps the control fields; power-on clears them.
    axi_write(OFF_CONTROL, 32'h0000_4042, RESP_OKAY);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_read(OFF_CONTROL, 32'h0000_6042, RESP_OKAY);
    aresetn <= 1'b0;
    por_n <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    por_n <= 1'b1;
    @(posedge aclk);
    axi_read(OFF_CONTROL, 32'h0, RESP_OKAY);
    stop_test();
  end
endmodule : flash_self_program_control_bench
`default_nettype wire
